// file: design/lpe_engine.sv
// lpe_engine: flash period sequencer, two on-time timers with ramps, and
// per-channel drive gate and current setting.
// assumes a plain register port from a bus bridge and an analog sink that
// takes the drive gate and the current code per channel.
//
// Summary of operation
// - period codes 0..0x7e repeat; code 0x7f runs one flash only.
// - each timer's on time covers its rise ramp plus full-on time.
// - rise and fall settings are four-bit codes 0 to 0xf.
// - a scaling factor multiplies both rise and fall ramp durations.
// - ramp shape selects linear or logarithmic brightness profile.
// - outside ramps the channel drive is steady, not pulsed.
// - during ramps a pwm duty rises or falls steadily.
// - rise and fall durations are separate independent settings.
// - every channel has its own current setting register.
// - each timer takes 0..255 as on time in 1/256 of the period.
// - two independent timers; channels may follow either one.
// - one channel may follow timer one while others are forced off.
// - second timer starts in one of four slots of the period.
// - each channel is on, off, following timer one or timer two.
// - the first timer always starts in the first slot.
//
// Added by the designer: the strobed register port and the placing of the registers.
`default_nettype none

module lpe_engine #(
  parameter int N_CHAN = 4,
  parameter int FRAC_CYC = lpe_pkg::FRAC_CYC,
  parameter int RAMP_CYC = lpe_pkg::RAMP_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // channel drive
  output logic [N_CHAN-1:0] o_chan_drive,
  output logic [8*N_CHAN-1:0] o_chan_current
);

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  logic [7:0] period_ramp_r;
  logic [7:0] first_timer_r;
  logic [7:0] second_timer_r;
  logic [7:0] slot_scale_r;
  logic [7:0] chan_mode_r;
  logic [7:0] ramp_time_r;
  logic pattern_wr;

  // any write to the pattern registers rearms a finished one-shot
  assign pattern_wr = i_wr && (i_addr <= lpe_pkg::ADR_RAMP_TIME);

  // pattern register writes
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      period_ramp_r <= lpe_pkg::RST_PERIOD_RAMP;
      first_timer_r <= lpe_pkg::RST_TIMER;
      second_timer_r <= lpe_pkg::RST_TIMER;
      slot_scale_r <= lpe_pkg::RST_SLOT_SCALE;
      chan_mode_r <= lpe_pkg::RST_CHAN_MODE;
      ramp_time_r <= lpe_pkg::RST_RAMP_TIME;
    end else if (i_wr) begin
      case (i_addr)
        lpe_pkg::ADR_PERIOD_RAMP: period_ramp_r <= i_wdata;
        lpe_pkg::ADR_FIRST_TIMER: first_timer_r <= i_wdata;
        lpe_pkg::ADR_SECOND_TIMER: second_timer_r <= i_wdata;
        lpe_pkg::ADR_SLOT_SCALE: slot_scale_r <= i_wdata;
        lpe_pkg::ADR_CHAN_MODE: chan_mode_r <= i_wdata;
        lpe_pkg::ADR_RAMP_TIME: ramp_time_r <= i_wdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // per-channel current settings
  // ------------------------------------------------------------------
  // the current code goes straight to the sink; it is the register itself
  genvar gc;
  generate
    for (gc = 0; gc < N_CHAN; gc++) begin : g_cur
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          o_chan_current[8*gc +: 8] <= lpe_pkg::RST_CURRENT;
        end else if (i_wr && i_addr == lpe_pkg::ADR_CURRENT0 + 4'(gc)) begin
          o_chan_current[8*gc +: 8] <= i_wdata;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // decoded fields
  // ------------------------------------------------------------------
  logic [6:0] period_code;
  logic shape_log;
  logic [1:0] slot_sel;
  logic [3:0] scale_mult;
  logic [3:0] rise_code;
  logic [3:0] fall_code;

  assign period_code = period_ramp_r[lpe_pkg::PERIOD_LSB +: 7];
  assign shape_log = period_ramp_r[lpe_pkg::SHAPE_BIT];
  assign slot_sel = slot_scale_r[lpe_pkg::SLOT_LSB +: 2];
  assign scale_mult = 4'h1 << slot_scale_r[lpe_pkg::SCALE_LSB +: 2];
  assign rise_code = ramp_time_r[lpe_pkg::RISE_LSB +: 4];
  assign fall_code = ramp_time_r[lpe_pkg::FALL_LSB +: 4];

  // ------------------------------------------------------------------
  // flash period sequencer
  // ------------------------------------------------------------------
  // the period is 256 fractional steps, each (code+1)*FRAC_CYC cycles,
  // counted in two stages so no wide multiplier is needed
  logic [15:0] frac_cyc_r;
  logic [6:0] frac_sub_r;
  logic [7:0] frac_r;
  logic frac_tick;
  logic period_end;
  lpe_pkg::lpe_seq_t seq_r;

  assign frac_tick = (frac_cyc_r == 16'(FRAC_CYC - 1)) && (frac_sub_r == period_code);
  assign period_end = frac_tick && (frac_r == 8'hff);

  // fractional position counters, frozen while a one-shot is finished
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frac_cyc_r <= 16'h0000;
      frac_sub_r <= 7'h00;
      frac_r <= 8'h00;
    end else if (seq_r == lpe_pkg::SEQ_HOLD) begin
      frac_cyc_r <= 16'h0000;
      frac_sub_r <= 7'h00;
      frac_r <= 8'h00;
    end else if (frac_cyc_r == 16'(FRAC_CYC - 1)) begin
      frac_cyc_r <= 16'h0000;
      if (frac_tick) begin
        frac_sub_r <= 7'h00;
        frac_r <= frac_r + 8'h01; // wraps to start the next period
      end else begin
        frac_sub_r <= frac_sub_r + 7'h01;
      end
    end else begin
      frac_cyc_r <= frac_cyc_r + 16'h0001;
    end
  end

  // repeat or stop at the period end
  // a period end in the same cycle as a rearming write still stops
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq_r <= lpe_pkg::SEQ_RUN;
    end else begin
      case (seq_r)
        lpe_pkg::SEQ_RUN: begin
          if (period_end && period_code == lpe_pkg::PERIOD_ONE_SHOT) begin
            seq_r <= lpe_pkg::SEQ_HOLD;
          end
        end
        lpe_pkg::SEQ_HOLD: begin
          if (pattern_wr) begin
            seq_r <= lpe_pkg::SEQ_RUN;
          end
        end
        default: seq_r <= lpe_pkg::SEQ_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // on-time windows
  // ------------------------------------------------------------------
  logic [1:0] win;
  logic [7:0] slot_start;
  logic [8:0] second_end;

  assign slot_start = {slot_sel, 6'h00};
  assign second_end = {1'b0, slot_start} + {1'b0, second_timer_r};

  // first window always opens at position zero; the second one cannot
  // reach past 255, so a late pulse is cut at the period end
  always_comb begin
    win = 2'b00;
    if (seq_r == lpe_pkg::SEQ_RUN) begin
      win[0] = frac_r < first_timer_r;
      win[1] = (frac_r >= slot_start) && ({1'b0, frac_r} < second_end);
    end
  end

  // ------------------------------------------------------------------
  // ramp base tick and pwm carrier
  // ------------------------------------------------------------------
  logic [15:0] ramp_div_r;
  logic ramp_tick;
  logic [7:0] pwm_cnt_r;

  assign ramp_tick = ramp_div_r == 16'(RAMP_CYC - 1);

  // shared by both timers so their ramps stay in step
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ramp_div_r <= 16'h0000;
      pwm_cnt_r <= 8'h00;
    end else begin
      ramp_div_r <= ramp_tick ? 16'h0000 : ramp_div_r + 16'h0001;
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // per-timer brightness level and gate
  // ------------------------------------------------------------------
  // the level climbs one step per interval while the window is open, so
  // the rise sits inside the on time; it falls after the window closes
  logic [1:0] gate;

  genvar gt;
  generate
    for (gt = 0; gt < 2; gt++) begin : g_tmr
      logic [7:0] level_r;
      logic [6:0] step_cnt_r;
      logic [6:0] step_len;
      logic [15:0] square;
      logic [7:0] shaped;

      // interval per level step: code times scaling factor
      assign step_len = 7'(win[gt] ? rise_code : fall_code) * 7'(scale_mult);
      assign square = level_r * level_r;
      assign shaped = shape_log ? square[15:8] : level_r;

      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          level_r <= 8'h00;
          step_cnt_r <= 7'h00;
        end else if (seq_r == lpe_pkg::SEQ_HOLD) begin
          level_r <= 8'h00;
          step_cnt_r <= 7'h00;
        end else if (win[gt] ? (level_r == lpe_pkg::LEVEL_FULL) : (level_r == 8'h00)) begin
          step_cnt_r <= 7'h00;
        end else if (step_len == 7'h00) begin
          // zero ramp code jumps straight to the end level
          level_r <= win[gt] ? lpe_pkg::LEVEL_FULL : 8'h00;
          step_cnt_r <= 7'h00;
        end else if (ramp_tick) begin
          if (step_cnt_r + 7'h01 >= step_len) begin
            step_cnt_r <= 7'h00;
            level_r <= win[gt] ? level_r + 8'h01 : level_r - 8'h01;
          end else begin
            step_cnt_r <= step_cnt_r + 7'h01;
          end
        end
      end

      // full or zero level gives a steady drive with no pulsing
      always_comb begin
        if (level_r == lpe_pkg::LEVEL_FULL) begin
          gate[gt] = 1'b1;
        end else begin
          gate[gt] = shaped > pwm_cnt_r;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // channel drive
  // ------------------------------------------------------------------
  // each channel picks its own source, so one channel can follow the
  // first timer while the rest sit in the off mode
  genvar gd;
  generate
    for (gd = 0; gd < N_CHAN; gd++) begin : g_drv
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          o_chan_drive[gd] <= 1'b0;
        end else begin
          case (chan_mode_r[2*gd +: 2])
            lpe_pkg::MODE_OFF: o_chan_drive[gd] <= 1'b0;
            lpe_pkg::MODE_ON: o_chan_drive[gd] <= 1'b1;
            lpe_pkg::MODE_FIRST: o_chan_drive[gd] <= gate[0];
            lpe_pkg::MODE_SECOND: o_chan_drive[gd] <= gate[1];
            default: o_chan_drive[gd] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] rd_mux;

  // status shows the sequencer and drive state for software polling
  always_comb begin
    status = 8'h00;
    status[lpe_pkg::STAT_HOLD_BIT] = seq_r == lpe_pkg::SEQ_HOLD;
    status[lpe_pkg::STAT_WIN1_BIT] = win[0];
    status[lpe_pkg::STAT_WIN2_BIT] = win[1];
    status[lpe_pkg::STAT_CHAN_LSB +: 4] = 4'(o_chan_drive);
  end

  // read select; unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      lpe_pkg::ADR_PERIOD_RAMP: rd_mux = period_ramp_r;
      lpe_pkg::ADR_FIRST_TIMER: rd_mux = first_timer_r;
      lpe_pkg::ADR_SECOND_TIMER: rd_mux = second_timer_r;
      lpe_pkg::ADR_SLOT_SCALE: rd_mux = {4'h0, slot_scale_r[3:0]};
      lpe_pkg::ADR_CHAN_MODE: rd_mux = chan_mode_r;
      lpe_pkg::ADR_RAMP_TIME: rd_mux = ramp_time_r;
      lpe_pkg::ADR_STATUS: rd_mux = status;
      default: begin
        if (i_addr >= lpe_pkg::ADR_CURRENT0 &&
            i_addr < lpe_pkg::ADR_CURRENT0 + 4'(N_CHAN)) begin
          rd_mux = o_chan_current[8*(i_addr - lpe_pkg::ADR_CURRENT0) +: 8];
        end
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

endmodule

`default_nettype wire

// file: design/lpe_pkg.sv
// lpe_pkg: register map, field layout, reset values, modes and timing counts
// of the led blink pattern engine.
// assumes a 20 MHz system clock and 8-bit register data.
`default_nettype none

package lpe_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // one 1/256 step of the flash period per period code unit
  localparam int FRAC_TIME_NS = 25000;
  localparam int FRAC_CYC = (FRAC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // base tick of the brightness ramps
  localparam int RAMP_TIME_NS = 2000;
  localparam int RAMP_CYC = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] ADR_PERIOD_RAMP = 4'h0;  // period_ramp_config
  localparam logic [3:0] ADR_FIRST_TIMER = 4'h1;  // first_timer_config
  localparam logic [3:0] ADR_SECOND_TIMER = 4'h2;
  localparam logic [3:0] ADR_SLOT_SCALE = 4'h3;
  localparam logic [3:0] ADR_CHAN_MODE = 4'h4;    // channel_mode_config
  localparam logic [3:0] ADR_RAMP_TIME = 4'h5;    // ramp_time_config
  localparam logic [3:0] ADR_CURRENT0 = 4'h6;     // channels at 6..9
  localparam logic [3:0] ADR_STATUS = 4'ha;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PERIOD_LSB = 0;   // 7 bits
  localparam int SHAPE_BIT = 7;    // 1 = logarithmic
  localparam int SLOT_LSB = 0;     // 2 bits
  localparam int SCALE_LSB = 2;    // 2 bits, factor 1,2,4,8
  localparam int RISE_LSB = 0;     // 4 bits
  localparam int FALL_LSB = 4;     // 4 bits
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_WIN1_BIT = 1;
  localparam int STAT_WIN2_BIT = 2;
  localparam int STAT_CHAN_LSB = 4;

  // ------------------------------------------------------------------
  // special values and reset values
  // ------------------------------------------------------------------
  localparam logic [6:0] PERIOD_MAX_REPEAT = 7'h7e;
  localparam logic [6:0] PERIOD_ONE_SHOT = 7'h7f;
  localparam logic [7:0] RST_PERIOD_RAMP = 8'h00;
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] RST_SLOT_SCALE = 8'h00;
  localparam logic [7:0] RST_CHAN_MODE = 8'h00;
  localparam logic [7:0] RST_RAMP_TIME = 8'h00;
  localparam logic [7:0] RST_CURRENT = 8'h00;
  localparam logic [7:0] LEVEL_FULL = 8'hff;

  // ------------------------------------------------------------------
  // channel modes (two bits per channel in channel_mode_config)
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_FIRST = 2'h2;   // follow_first_timer
  localparam logic [1:0] MODE_SECOND = 2'h3;  // follow_second_timer

  // period sequencer
  typedef enum logic {SEQ_RUN, SEQ_HOLD} lpe_seq_t;

endpackage

`default_nettype wire

// file: verif/lpe_checker.sv
// lpe_checker: port-level assertions for the pattern engine.
// assumes it is bound to lpe_engine and sees only its ports.
`default_nettype none

module lpe_checker #(
  parameter int N_CHAN = 4,
  parameter int FRAC_CYC = 2,
  parameter int RAMP_CYC = 2
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // channel drive
  input wire logic [N_CHAN-1:0] o_chan_drive,
  input wire logic [8*N_CHAN-1:0] o_chan_current
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic [7:0] mode_r;
  logic [7:0] mode_d;
  logic [3:0] on_m;
  logic [3:0] off_m;

  // shadow of the mode register; mode_d lags so the output flop has landed
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r <= 8'h00;
      mode_d <= 8'h00;
    end else begin
      if (i_wr && i_addr == lpe_pkg::ADR_CHAN_MODE) mode_r <= i_wdata;
      mode_d <= mode_r;
    end
  end

  // channels held plainly on or off by their mode
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      on_m[c] = mode_r[2*c +: 2] == lpe_pkg::MODE_ON;
      off_m[c] = mode_r[2*c +: 2] == lpe_pkg::MODE_OFF;
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_cur_wr;
    i_wr && i_addr == lpe_pkg::ADR_CURRENT0 |=> o_chan_current[7:0] == $past(i_wdata);
  endproperty
  a_cur_wr: assert property (p_cur_wr) else $error("current write lost");
  property p_cur_hold;
    !(i_wr && i_addr >= 4'h6 && i_addr <= 4'h9) |=> $stable(o_chan_current);
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("current moved");
  property p_rd_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rd_cur;
    i_rd && i_addr == lpe_pkg::ADR_CURRENT0 |=> o_rdata == $past(o_chan_current[7:0]);
  endproperty
  a_rd_cur: assert property (p_rd_cur) else $error("current readback wrong");
  property p_rd_mode;
    i_rd && i_addr == lpe_pkg::ADR_CHAN_MODE |=> o_rdata == $past(mode_r);
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode readback wrong");
  property p_rd_unmap;
    i_rd && i_addr > lpe_pkg::ADR_STATUS |=> o_rdata == 8'h00;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  property p_on;
    mode_r == mode_d |-> (o_chan_drive[3:0] & on_m) == on_m;
  endproperty
  a_on: assert property (p_on) else $error("on channel not steady");
  property p_off;
    mode_r == mode_d |-> (o_chan_drive[3:0] & off_m) == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("off channel driven");

  // main scenarios reached
  c_status: cover property (i_rd && i_addr == lpe_pkg::ADR_STATUS);
  c_rise: cover property ($rose(o_chan_drive[1]));
  c_shot: cover property (i_wr && i_addr == 4'h0 && i_wdata[6:0] == 7'h7f);
endmodule

bind lpe_engine lpe_checker #(.N_CHAN(N_CHAN), .FRAC_CYC(FRAC_CYC), .RAMP_CYC(RAMP_CYC)) u_chk (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chan_drive(o_chan_drive),
  .o_chan_current(o_chan_current));

`default_nettype wire

// file: verif/lpe_host.sv
// lpe_host: host side model driving the plain register port.
// assumes the engine never stalls; strobes last exactly one cycle.
`default_nettype none

module lpe_host (
  // clock
  input wire logic i_clk_sys,
  // register port toward the engine
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // one-cycle write, launched just after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
  endtask

  // one-cycle read; the bench picks up the data a cycle later
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: verif/led_blink_pattern_engine_tb.sv
// led_blink_pattern_engine_tb: self-checking bench for lpe_engine.
// assumes short sim counts: FRAC_CYC 2, RAMP_CYC 2.
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module led_blink_pattern_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // period code 3 gives 4*2 cycles per 1/256 step
  localparam int PER = 2048;
  logic i_clk_sys = 1'b0;
  logic i_reset_n;
  wire logic [3:0] addr;
  wire logic [7:0] wdata;
  wire logic wr;
  wire logic rd;
  logic [7:0] o_rdata;
  logic [3:0] o_chan_drive;
  logic [31:0] o_chan_current;
  int errors, n_checks, seed, lin, v;
  int hi[4];
  int rp[4];
  logic [15:0] q[$];
  logic [15:0] note;
  logic rd_q = 1'b0;

  always #25 i_clk_sys = ~i_clk_sys;

  lpe_host u_host (.i_clk_sys(i_clk_sys), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  lpe_engine #(.FRAC_CYC(2), .RAMP_CYC(2)) DUT (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata),
    .o_chan_drive(o_chan_drive), .o_chan_current(o_chan_current));

  // read data stand one cycle after the strobe; match with the oldest note
  always @(posedge i_clk_sys) begin
    if (rd_q) begin
      note = q.pop_front();
      `CHK(o_rdata & note[15:8], note[7:0])
    end
    rd_q <= rd;
  end

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({m, e & m});
    u_host.rd(a);
  endtask

  // fixed second timer and modes: ch0 first, ch1 second, ch2 on, ch3 off
  task automatic cfg(input logic [7:0] p, input logic [7:0] t1, input logic [7:0] ss,
                     input logic [7:0] rf);
    u_host.wr(lpe_pkg::ADR_PERIOD_RAMP, p);
    u_host.wr(lpe_pkg::ADR_FIRST_TIMER, t1);
    u_host.wr(lpe_pkg::ADR_SECOND_TIMER, 8'h20);
    u_host.wr(lpe_pkg::ADR_SLOT_SCALE, ss);
    u_host.wr(lpe_pkg::ADR_RAMP_TIME, rf);
    u_host.wr(lpe_pkg::ADR_CHAN_MODE, 8'h1e);
    repeat (300) @(posedge i_clk_sys);
  endtask

  // one whole period: high cycles and last rising edge per channel
  task automatic meas();
    logic [3:0] pv;
    pv = o_chan_drive;
    hi = '{default: 0};
    for (int i = 0; i < PER; i++) begin
      @(posedge i_clk_sys);
      for (int c = 0; c < 4; c++) begin
        if (o_chan_drive[c] === 1'b1) hi[c]++;
        if (o_chan_drive[c] === 1'b1 && pv[c] === 1'b0) rp[c] = i;
      end
      pv = o_chan_drive;
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: all tests need about 97.3k cycles, one-shot wait dominates
  initial begin
    #(99000 * 50);
    errors++;
    summarize();
  end

  initial begin
    i_reset_n = 1'b0;
    errors = 0;
    n_checks = 0;
    seed = 32'hddba;
    repeat (5) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    for (int a = 0; a < 16; a++) rd_exp(a[3:0], 8'h00, 8'hff);
    $display("test reset values done");
    // random readback; status and unused places ignore writes
    for (int a = 0; a < 16; a++) begin
      v = $random(seed);
      u_host.wr(a[3:0], v[7:0]);
      if (a != 10) rd_exp(a[3:0], a == 3 ? v[7:0] & 8'h0f : a > 10 ? 8'h00 : v[7:0],
                          8'hff);
      if (a >= 6 && a <= 9) `CHK(o_chan_current[8*(a-6) +: 8], v[7:0])
    end
    $display("test register readback done");
    for (int s = 0; s < 4; s++) begin
      cfg(8'h03, 8'h40, s[7:0], 8'h00);
      meas();
      `CHK(hi[0], 512)
      `CHK(hi[1], 256)
      `CHK(hi[2], PER)
      `CHK(hi[3], 0)
      `CHK((rp[1] - rp[0] + PER) % PER, s * 512)
    end
    // slot 3 with a long second timer: pulse is cut at the period end
    u_host.wr(lpe_pkg::ADR_SECOND_TIMER, 8'h80);
    repeat (300) @(posedge i_clk_sys);
    meas();
    `CHK(hi[1], 512)
    $display("test slots done");
    // ramps carry level across a settings change, so let one period pass
    cfg(8'h03, 8'h80, 8'h00, 8'h01);
    repeat (PER) @(posedge i_clk_sys);
    meas();
    lin = hi[0];
    `CHK(lin > 512 && lin < 1024, 1'b1)
    cfg(8'h83, 8'h80, 8'h00, 8'h01);
    repeat (PER) @(posedge i_clk_sys);
    meas();
    `CHK(hi[0] < lin, 1'b1)
    cfg(8'h03, 8'h80, 8'h04, 8'h01);
    repeat (PER) @(posedge i_clk_sys);
    meas();
    `CHK(hi[0] < lin, 1'b1)
    cfg(8'h03, 8'h80, 8'h00, 8'h10);
    repeat (PER) @(posedge i_clk_sys);
    meas();
    `CHK(hi[0] > 1024, 1'b1)
    $display("test ramps done");
    // single flash lasts 128*2*256 cycles
    cfg(8'h7f, 8'h40, 8'h00, 8'h00);
    repeat (65400) @(posedge i_clk_sys);
    rd_exp(lpe_pkg::ADR_STATUS, 8'h41, 8'hf1);
    meas();
    `CHK(hi[0] + hi[1], 0)
    `CHK(hi[2], PER)
    u_host.wr(lpe_pkg::ADR_CHAN_MODE, 8'h1e);
    repeat (4) @(posedge i_clk_sys);
    rd_exp(lpe_pkg::ADR_STATUS, 8'h10, 8'h11);
    repeat (3) @(posedge i_clk_sys);
    $display("test one shot done");
    summarize();
  end
endmodule

`default_nettype wire
